/* File: amcac_defines.svh */
// Operation
// - velocity move on first scan refused, 38h
// - velocity move with drive disabled refused, 39h
// - velocity move with program selected refused, 3Ah
// - velocity move during home cycle refused, 3Bh
// - velocity move while jog bit set refused, 3Ch
// - velocity move while abort bit set refused, 3Dh
// - velocity above user-unit limit refused, 3Eh
// - scaled velocity above count limit refused, 3Fh
// - jog during find home refused, 40h
// - jog during velocity move refused, 41h
// - jog while forced command present refused, 42h
// - jog with program selected needs feedhold, 43h
// - forced command during jog refused, 47h
// - forced command during velocity move refused, 48h
// - forced command with program selected refused, 49h
// - forced command with follower enabled refused, 4Ah
`ifndef AMCAC_DEFINES_SVH
`define AMCAC_DEFINES_SVH

// register word addresses on the plain register port
`define AMCAC_ADDR_VEL        8'h00
`define AMCAC_ADDR_CMD        8'h04
`define AMCAC_ADDR_CTRL       8'h08
`define AMCAC_ADDR_SCALE      8'h0c
`define AMCAC_ADDR_STATUS     8'h10

// command codes carried in the low byte of the host command word
`define AMCAC_CMD_NONE        8'h00
`define AMCAC_CMD_VMOVE       8'h22
`define AMCAC_CMD_FAOUT       8'h24
`define AMCAC_CMD_FSVEL       8'h34

// control register bit positions
`define AMCAC_CTRL_DRV_EN     0
`define AMCAC_CTRL_ABORT      1
`define AMCAC_CTRL_JOG_FWD    2
`define AMCAC_CTRL_JOG_REV    3
`define AMCAC_CTRL_FEEDHOLD   4
`define AMCAC_CTRL_FIRST_SCAN 5

// status register bit positions, error code sits in bits 7:0
`define AMCAC_STAT_ERR_VALID  8
`define AMCAC_STAT_MOVE       9
`define AMCAC_STAT_JOG        10
`define AMCAC_STAT_FORCE      11
`define AMCAC_STAT_ANALOG     12

// scale register fields and reset values
`define AMCAC_SCALE_SHIFT_LSB 16
`define AMCAC_SCALE_NUM_RST   16'h0001
`define AMCAC_SCALE_SHIFT_RST 5'h00

// error codes
`define AMCAC_ERR_NONE        8'h00
`define AMCAC_ERR_VM_SCAN     8'h38
`define AMCAC_ERR_VM_DRIVE    8'h39
`define AMCAC_ERR_VM_PROG     8'h3a
`define AMCAC_ERR_VM_HOME     8'h3b
`define AMCAC_ERR_VM_JOG      8'h3c
`define AMCAC_ERR_VM_ABORT    8'h3d
`define AMCAC_ERR_VM_USER     8'h3e
`define AMCAC_ERR_VM_COUNTS   8'h3f
`define AMCAC_ERR_JG_HOME     8'h40
`define AMCAC_ERR_JG_VMOVE    8'h41
`define AMCAC_ERR_JG_FORCE    8'h42
`define AMCAC_ERR_JG_PROG     8'h43
`define AMCAC_ERR_FC_JOG      8'h47
`define AMCAC_ERR_FC_VMOVE    8'h48
`define AMCAC_ERR_FC_PROG     8'h49
`define AMCAC_ERR_FC_FOLLOW   8'h4a

// velocity limits: 8,388,607 user units/s and 1,000,000 counts/s
`define AMCAC_MAX_USER_VEL    32'h007fffff
`define AMCAC_MAX_CNT_VEL     48'h0000000f4240

`endif

/* File: amcac_pkg.sv */
package amcac_pkg;

	// axis activity; the three motions exclude each other
	typedef enum logic [1:0] {
		ACT_IDLE  = 2'b00,
		ACT_VMOVE = 2'b01,
		ACT_JOG   = 2'b10,
		ACT_FORCE = 2'b11
	} amcac_act_e;

	// one register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} amcac_req_s;

	// host discrete control bits
	typedef struct packed {
		logic first_scan;
		logic feedhold;
		logic jog_rev;
		logic jog_fwd;
		logic abort_all;
		logic drive_en;
	} amcac_ctrl_s;

	// magnitude of a two's complement word; min value maps to 80000000h unsigned
	function automatic logic [31:0] amcac_abs32(input logic [31:0] v);
		return v[31] ? (32'h00000000 - v) : v;
	endfunction

endpackage

/* File: amcac_vel_check.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amcac_defines.svh"

// velocity limit screening and user-unit to count scaling
module amcac_vel_check import amcac_pkg::*; (
	input  wire logic [31:0] vel,
	input  wire logic [15:0] scale_num,
	input  wire logic [4:0]  scale_shift,
	output logic             over_user,
	output logic             over_counts,
	output logic [31:0]      vel_counts
);

	logic [31:0] mag;
	logic [47:0] prod;
	logic [47:0] scaled;

	// full 48-bit product so no overflow hides an over-limit request
	assign mag         = amcac_abs32(vel);
	assign prod        = {16'h0000, mag} * {32'h00000000, scale_num};
	assign scaled      = prod >> scale_shift;
	assign over_user   = mag > `AMCAC_MAX_USER_VEL;
	assign over_counts = scaled > `AMCAC_MAX_CNT_VEL;
	// sign restored; only meaningful when over_counts is low
	assign vel_counts  = vel[31] ? (32'h00000000 - scaled[31:0]) : scaled[31:0];

endmodule
`default_nettype wire

/* File: amcac_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amcac_defines.svh"

// per-axis admission checker for velocity, jog and forced commands
module amcac_top import amcac_pkg::*; (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire amcac_req_s bus_req,
	input  wire logic       program_selected,
	input  wire logic       home_active,
	input  wire logic       follower_enabled,
	output logic [31:0]     rdata,
	output logic            move_active,
	output logic            jog_active,
	output logic            force_active,
	output logic            force_analog,
	output logic [31:0]     vel_command,
	output logic [7:0]      err_code,
	output logic            err_valid,
	output logic            err_pulse
);

	amcac_act_e  act;
	amcac_act_e  next_act;
	amcac_ctrl_s ctrl;
	amcac_ctrl_s wr_ctrl_val;
	amcac_ctrl_s next_ctrl;
	logic [31:0] vel_reg;
	logic [15:0] scale_num;
	logic [4:0]  scale_shift;
	logic [31:0] next_rdata;
	logic [31:0] next_vel_command;
	logic        next_err_valid;

	logic        wr_vel;
	logic        wr_cmd;
	logic        wr_ctrl;
	logic        wr_scale;
	logic        wr_status;
	logic [7:0]  cmd_code;
	logic        cmd_vmove;
	logic        cmd_force;
	logic        cmd_none;
	logic        jog_bits_now;
	logic        jog_bits_new;
	logic        jog_req;
	logic        vmove_pre_ok;
	logic        over_user;
	logic        over_counts;
	logic [31:0] vel_counts;
	logic [7:0]  vmove_err;
	logic [7:0]  jog_err;
	logic [7:0]  force_err;
	logic [7:0]  refuse_code;
	logic        refuse;
	logic        accept;
	logic        stop_req;
	logic        err_clr;
	logic [31:0] status_word;

	// write strobes per register
	assign wr_vel    = bus_req.wr && (bus_req.addr == `AMCAC_ADDR_VEL);
	assign wr_cmd    = bus_req.wr && (bus_req.addr == `AMCAC_ADDR_CMD);
	assign wr_ctrl   = bus_req.wr && (bus_req.addr == `AMCAC_ADDR_CTRL);
	assign wr_scale  = bus_req.wr && (bus_req.addr == `AMCAC_ADDR_SCALE);
	assign wr_status = bus_req.wr && (bus_req.addr == `AMCAC_ADDR_STATUS);

	// command word and control word decode
	assign cmd_code     = bus_req.wdata[7:0];
	assign cmd_vmove    = wr_cmd && (cmd_code == `AMCAC_CMD_VMOVE);
	assign cmd_force    = wr_cmd && ((cmd_code == `AMCAC_CMD_FSVEL) ||
		(cmd_code == `AMCAC_CMD_FAOUT));
	assign cmd_none     = wr_cmd && (cmd_code == `AMCAC_CMD_NONE);
	assign wr_ctrl_val  = bus_req.wdata[5:0];
	assign next_ctrl    = wr_ctrl ? wr_ctrl_val : ctrl;
	assign jog_bits_now = ctrl.jog_fwd | ctrl.jog_rev;
	assign jog_bits_new = wr_ctrl_val.jog_fwd | wr_ctrl_val.jog_rev;
	// a jog request is a control write that raises the OR of the jog bit pair from zero
	assign jog_req      = wr_ctrl && jog_bits_new && !jog_bits_now;

	amcac_vel_check u_vel_check (
		.vel         (vel_reg),
		.scale_num   (scale_num),
		.scale_shift (scale_shift),
		.over_user   (over_user),
		.over_counts (over_counts),
		.vel_counts  (vel_counts)
	);

	// velocity move screening, highest priority first
	assign vmove_pre_ok = !ctrl.first_scan && ctrl.drive_en && !program_selected &&
		!home_active && !jog_bits_now && !ctrl.abort_all;
	assign vmove_err =
		ctrl.first_scan  ? `AMCAC_ERR_VM_SCAN   :
		!ctrl.drive_en   ? `AMCAC_ERR_VM_DRIVE  :
		program_selected ? `AMCAC_ERR_VM_PROG   :
		home_active      ? `AMCAC_ERR_VM_HOME   :
		jog_bits_now     ? `AMCAC_ERR_VM_JOG    :
		ctrl.abort_all   ? `AMCAC_ERR_VM_ABORT  :
		over_user        ? `AMCAC_ERR_VM_USER   :
		over_counts      ? `AMCAC_ERR_VM_COUNTS :
		`AMCAC_ERR_NONE;

	// jog screening; feedhold is taken from the same control write
	assign jog_err =
		home_active               ? `AMCAC_ERR_JG_HOME  :
		(act == ACT_VMOVE)        ? `AMCAC_ERR_JG_VMOVE :
		(act == ACT_FORCE)        ? `AMCAC_ERR_JG_FORCE :
		(program_selected && !wr_ctrl_val.feedhold) ? `AMCAC_ERR_JG_PROG :
		`AMCAC_ERR_NONE;

	// forced servo velocity / analog output screening
	assign force_err =
		(act == ACT_JOG)   ? `AMCAC_ERR_FC_JOG    :
		(act == ACT_VMOVE) ? `AMCAC_ERR_FC_VMOVE  :
		program_selected   ? `AMCAC_ERR_FC_PROG   :
		follower_enabled   ? `AMCAC_ERR_FC_FOLLOW :
		`AMCAC_ERR_NONE;

	// only one request kind can arrive per cycle, so one code at most
	assign refuse_code = cmd_vmove ? vmove_err : cmd_force ? force_err :
		jog_req ? jog_err : `AMCAC_ERR_NONE;
	assign refuse  = refuse_code != `AMCAC_ERR_NONE;
	assign accept  = (cmd_vmove || cmd_force || jog_req) && !refuse;
	assign err_clr = wr_status && bus_req.wdata[`AMCAC_STAT_ERR_VALID];
	// drive loss or abort ends a running move or jog; a force keeps running
	assign stop_req = next_ctrl.abort_all || !next_ctrl.drive_en;

	// activity state; a refused request leaves it alone unless its control write also aborts or drops the drive
	always_comb begin
		next_act = act;
		case (act)
			ACT_IDLE: begin
				if (accept && cmd_vmove) begin
					next_act = ACT_VMOVE;
				end else if (accept && cmd_force) begin
					next_act = ACT_FORCE;
				end else if (accept && jog_req) begin
					next_act = ACT_JOG;
				end
			end
			ACT_VMOVE: begin
				if (stop_req || cmd_none) begin
					next_act = ACT_IDLE;
				end
			end
			ACT_JOG: begin
				if (stop_req || !(next_ctrl.jog_fwd | next_ctrl.jog_rev)) begin
					next_act = ACT_IDLE;
				end
			end
			ACT_FORCE: begin
				if (cmd_none) begin
					next_act = ACT_IDLE;
				end else if (accept && cmd_vmove) begin
					next_act = ACT_VMOVE;
				end
			end
			default: begin
				next_act = ACT_IDLE;
			end
		endcase
	end

	// command velocity follows accepted data, zero once idle
	assign next_vel_command = (accept && (cmd_vmove || cmd_force)) ? vel_counts :
		(next_act == ACT_IDLE || next_act == ACT_JOG) ? 32'h00000000 : vel_command;
	// set wins over a software clear in the same cycle
	assign next_err_valid = refuse || (err_valid && !err_clr);

	assign status_word = {19'h00000, force_analog, force_active, jog_active, move_active,
		err_valid, err_code};

	// read mux; unmapped addresses read zero
	always_comb begin
		if (!bus_req.rd) begin
			next_rdata = 32'h00000000;
		end else if (bus_req.addr == `AMCAC_ADDR_VEL) begin
			next_rdata = vel_reg;
		end else if (bus_req.addr == `AMCAC_ADDR_CTRL) begin
			next_rdata = {26'h0000000, ctrl};
		end else if (bus_req.addr == `AMCAC_ADDR_SCALE) begin
			next_rdata = {11'h000, scale_shift, scale_num};
		end else if (bus_req.addr == `AMCAC_ADDR_STATUS) begin
			next_rdata = status_word;
		end else begin
			next_rdata = 32'h00000000;
		end
	end

	// software registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vel_reg     <= 32'h00000000;
			ctrl        <= 6'h00;
			scale_num   <= `AMCAC_SCALE_NUM_RST;
			scale_shift <= `AMCAC_SCALE_SHIFT_RST;
			rdata       <= 32'h00000000;
		end else begin
			vel_reg     <= wr_vel ? bus_req.wdata : vel_reg;
			ctrl        <= next_ctrl;
			scale_num   <= wr_scale ? bus_req.wdata[15:0] : scale_num;
			scale_shift <= wr_scale ? bus_req.wdata[20:16] : scale_shift;
			rdata       <= next_rdata;
		end
	end

	// activity and motion outputs, untouched by a refusal unless its control write aborts or drops the drive
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			act          <= ACT_IDLE;
			move_active  <= 1'b0;
			jog_active   <= 1'b0;
			force_active <= 1'b0;
			force_analog <= 1'b0;
			vel_command  <= 32'h00000000;
		end else begin
			act          <= next_act;
			move_active  <= next_act == ACT_VMOVE;
			jog_active   <= next_act == ACT_JOG;
			force_active <= next_act == ACT_FORCE;
			force_analog <= (accept && cmd_force) ? (cmd_code == `AMCAC_CMD_FAOUT) :
				(force_analog && next_act == ACT_FORCE);
			vel_command  <= next_vel_command;
		end
	end

	// status-only error report; the last refusal's code is held
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_code  <= `AMCAC_ERR_NONE;
			err_valid <= 1'b0;
			err_pulse <= 1'b0;
		end else begin
			err_code  <= refuse ? refuse_code : err_code;
			err_valid <= next_err_valid;
			err_pulse <= refuse;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_vm_first_scan: assert property (cmd_vmove && ctrl.first_scan |=>
		err_pulse && err_code == 8'h38) else $error("first scan move not refused");
	a_vm_drive_off: assert property (cmd_vmove && !ctrl.first_scan && !ctrl.drive_en
		|=> err_code == 8'h39 && !move_active) else $error("drive off move not refused");
	a_vm_prog_sel: assert property (cmd_vmove && !ctrl.first_scan && ctrl.drive_en &&
		program_selected |=> err_code == 8'h3a) else $error("program move not refused");
	a_vm_home: assert property (cmd_vmove && !ctrl.first_scan && ctrl.drive_en &&
		!program_selected && home_active |=> err_code == 8'h3b) else $error("home move not refused");
	a_vm_jog_bit: assert property (cmd_vmove && vmove_pre_ok == 1'b0 && !ctrl.first_scan &&
		ctrl.drive_en && !program_selected && !home_active && jog_bits_now
		|=> err_code == 8'h3c) else $error("jog bit move not refused");
	a_vm_abort: assert property (cmd_vmove && !jog_bits_now && !ctrl.first_scan &&
		ctrl.drive_en && !program_selected && !home_active && ctrl.abort_all
		|=> err_pulse && err_code == 8'h3d) else $error("abort move not refused");
	a_vm_user_lim: assert property (cmd_vmove && vmove_pre_ok &&
		amcac_abs32(vel_reg) > 32'h007fffff |=> err_code == 8'h3e)
		else $error("user velocity limit missed");
	a_vm_count_lim: assert property (cmd_vmove && vmove_pre_ok && !over_user && over_counts
		|=> err_code == 8'h3f) else $error("count velocity limit missed");
	a_vm_accept: assert property (cmd_vmove && vmove_pre_ok && !over_user && !over_counts
		|=> move_active && !err_pulse && vel_command == $past(vel_counts))
		else $error("clean move not accepted");
	a_jog_home: assert property (jog_req && home_active |=> err_code == 8'h40
		&& !jog_active) else $error("jog during home not refused");
	a_jog_vmove: assert property (jog_req && !home_active && act == ACT_VMOVE
		|=> err_code == 8'h41 && move_active == !$past(stop_req))
		else $error("jog during move not refused");
	a_jog_force: assert property (jog_req && !home_active && act == ACT_FORCE
		|=> err_code == 8'h42 && force_active) else $error("jog during force not refused");
	a_jog_feedhold: assert property (jog_req && !home_active && act == ACT_IDLE &&
		program_selected |=> jog_active == $past(wr_ctrl_val.feedhold))
		else $error("feedhold jog gating wrong");
	a_fc_jog: assert property (cmd_force && act == ACT_JOG
		|=> err_code == 8'h47 && !force_active) else $error("force during jog not refused");
	a_fc_vmove: assert property (cmd_force && act == ACT_VMOVE |=> err_code == 8'h48
		&& $stable(vel_command)) else $error("force during move not refused");
	a_fc_prog: assert property (cmd_force && act == ACT_IDLE && program_selected
		|=> err_code == 8'h49) else $error("force with program not refused");
	a_fc_follow: assert property (cmd_force && act == ACT_IDLE && !program_selected &&
		follower_enabled |=> err_code == 8'h4a) else $error("force with follower not refused");
	// an abort or drive loss written with the refused request still ends a move
	a_refuse_holds: assert property (refuse |=> err_valid &&
		(act == $past(act) || ($past(stop_req) && act == ACT_IDLE)))
		else $error("refusal disturbed motion");
	a_one_code: assert property (cmd_vmove && ctrl.first_scan && home_active
		|=> err_code == 8'h38) else $error("priority order broken");

	c_move_ok: cover property (cmd_vmove && vmove_pre_ok ##1 move_active);
	c_jog_feedhold: cover property (jog_req && program_selected ##1 jog_active);
	c_force_analog: cover property (cmd_force ##1 force_analog);
	c_err_clear: cover property (err_valid && err_clr ##1 !err_valid);

endmodule
`default_nettype wire

/* File: amcac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host controller: owns the register port and the axis indication lines
module amcac_host_model import amcac_pkg::*; (
	input  wire logic        clock,
	input  wire logic [31:0] rdata,
	output var amcac_req_s   bus_req,
	output var logic         program_selected,
	output var logic         home_active,
	output var logic         follower_enabled
);

	// idle bus and quiet indications from time zero
	initial begin
		bus_req = '0;
		program_selected = 1'b0;
		home_active = 1'b0;
		follower_enabled = 1'b0;
	end

	// one-cycle write strobe; idle address and data are scrambled so nothing
	// downstream can lean on a stale value
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one-cycle read strobe, data taken only in the cycle after it
	task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h5a5a5a5a};
		@(posedge clock);
		bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'ha5a5a5a5};
		#1;
		d = rdata;
	endtask

	// program, home and follower levels move right after an edge
	task automatic set_ind(input logic p, input logic h, input logic f);
		@(posedge clock);
		program_selected <= p;
		home_active <= h;
		follower_enabled <= f;
	endtask

endmodule

`default_nettype wire

/* File: amcac_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amcac_defines.svh"

module amcac_top_test import amcac_pkg::*;;

	localparam logic [7:0]  a_vel   = `AMCAC_ADDR_VEL;
	localparam logic [7:0]  a_cmd   = `AMCAC_ADDR_CMD;
	localparam logic [7:0]  a_ctrl  = `AMCAC_ADDR_CTRL;
	localparam logic [7:0]  a_scale = `AMCAC_ADDR_SCALE;
	localparam logic [7:0]  a_stat  = `AMCAC_ADDR_STATUS;
	localparam logic [31:0] drv     = 32'h00000001 << `AMCAC_CTRL_DRV_EN;
	localparam logic [31:0] abrt    = 32'h00000001 << `AMCAC_CTRL_ABORT;
	localparam logic [31:0] jfwd    = 32'h00000001 << `AMCAC_CTRL_JOG_FWD;
	localparam logic [31:0] jrev    = 32'h00000001 << `AMCAC_CTRL_JOG_REV;
	localparam logic [31:0] fhold   = 32'h00000001 << `AMCAC_CTRL_FEEDHOLD;
	localparam logic [31:0] fscan   = 32'h00000001 << `AMCAC_CTRL_FIRST_SCAN;
	localparam logic [31:0] vm      = {24'h000000, `AMCAC_CMD_VMOVE};
	localparam logic [31:0] fs      = {24'h000000, `AMCAC_CMD_FSVEL};
	localparam logic [31:0] fa      = {24'h000000, `AMCAC_CMD_FAOUT};

	logic        clock;
	logic        rst_n;
	amcac_req_s  bus_req;
	logic        program_selected;
	logic        home_active;
	logic        follower_enabled;
	logic [31:0] rdata;
	logic        move_active;
	logic        jog_active;
	logic        force_active;
	logic        force_analog;
	logic [31:0] vel_command;
	logic [7:0]  err_code;
	logic        err_valid;
	logic        err_pulse;
	int          err_count = 0;
	int          total_checks = 0;

	amcac_top uut (
		.clock            (clock),
		.rst_n            (rst_n),
		.bus_req          (bus_req),
		.program_selected (program_selected),
		.home_active      (home_active),
		.follower_enabled (follower_enabled),
		.rdata            (rdata),
		.move_active      (move_active),
		.jog_active       (jog_active),
		.force_active     (force_active),
		.force_analog     (force_analog),
		.vel_command      (vel_command),
		.err_code         (err_code),
		.err_valid        (err_valid),
		.err_pulse        (err_pulse)
	);

	amcac_host_model host (
		.clock            (clock),
		.rdata            (rdata),
		.bus_req          (bus_req),
		.program_selected (program_selected),
		.home_active      (home_active),
		.follower_enabled (follower_enabled)
	);

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] got;
		host.read_reg(a, got);
		check(what, exp, got);
	endtask

	// write, then judge the answer in the single cycle the pulse stands;
	// code 00h means the request must be taken, act is {move, jog, force}
	task automatic send(input logic [7:0] a, input logic [31:0] d, input logic [7:0] code,
			input logic [2:0] act);
		host.write_reg(a, d);
		#1;
		check("err_pulse", {31'h0, code != 8'h00}, {31'h0, err_pulse});
		if (code != 8'h00) begin
			check("err_code", {24'h0, code}, {24'h0, err_code});
			check("err_valid", 32'h1, {31'h0, err_valid});
		end
		check("activity", {29'h0, act}, {29'h0, move_active, jog_active, force_active});
	endtask

	// a hang ends the run through the same report
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		final_report();
	end

	initial begin
		rst_n = 1'b0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		// unmapped write must leave every register at its reset value
		host.write_reg(8'h14, 32'hffffffff);
		expect_reg(8'h14, 32'h0, "unmapped");
		expect_reg(a_cmd, 32'h0, "cmd");
		expect_reg(a_vel, 32'h0, "vel");
		expect_reg(a_stat, 32'h0, "status");
		expect_reg(a_ctrl, 32'h0, "ctrl");
		expect_reg(a_scale, {11'h0, `AMCAC_SCALE_SHIFT_RST, `AMCAC_SCALE_NUM_RST}, "scale");
		@(posedge clock);
		#1;
		check("rdata idle", 32'h0, rdata);
		// every fault at once, then lift them one at a time
		host.set_ind(1'b1, 1'b1, 1'b0);
		host.write_reg(a_vel, 32'h00800000);
		send(a_ctrl, fscan | abrt | jfwd, `AMCAC_ERR_JG_HOME, 3'b000);
		@(posedge clock);
		#1;
		check("err_pulse end", 32'h0, {31'h0, err_pulse});
		send(a_cmd, vm, `AMCAC_ERR_VM_SCAN, 3'b000);
		host.write_reg(a_ctrl, abrt | jfwd);
		send(a_cmd, vm, `AMCAC_ERR_VM_DRIVE, 3'b000);
		host.write_reg(a_ctrl, drv | abrt | jfwd);
		send(a_cmd, vm, `AMCAC_ERR_VM_PROG, 3'b000);
		host.set_ind(1'b0, 1'b1, 1'b0);
		send(a_cmd, vm, `AMCAC_ERR_VM_HOME, 3'b000);
		host.set_ind(1'b0, 1'b0, 1'b0);
		send(a_cmd, vm, `AMCAC_ERR_VM_JOG, 3'b000);
		host.write_reg(a_ctrl, drv | abrt);
		send(a_cmd, vm, `AMCAC_ERR_VM_ABORT, 3'b000);
		host.write_reg(a_ctrl, drv);
		send(a_cmd, vm, `AMCAC_ERR_VM_USER, 3'b000);
		host.write_reg(a_vel, 32'h007fffff);
		send(a_cmd, vm, `AMCAC_ERR_VM_COUNTS, 3'b000);
		host.write_reg(a_vel, 32'd1000001);
		send(a_cmd, vm, `AMCAC_ERR_VM_COUNTS, 3'b000);
		host.write_reg(a_vel, 32'd1000000);
		send(a_cmd, vm, 8'h00, 3'b100);
		check("vel_command", 32'd1000000, vel_command);
		// refusals while moving must not disturb the move
		send(a_ctrl, drv | jfwd, `AMCAC_ERR_JG_VMOVE, 3'b100);
		host.write_reg(a_ctrl, drv);
		send(a_cmd, fs, `AMCAC_ERR_FC_VMOVE, 3'b100);
		check("vel_command", 32'd1000000, vel_command);
		send(a_cmd, 32'h0, 8'h00, 3'b000);
		// forced commands: program and follower block, then a scaled negative force
		host.set_ind(1'b1, 1'b0, 1'b0);
		send(a_cmd, fs, `AMCAC_ERR_FC_PROG, 3'b000);
		host.set_ind(1'b0, 1'b0, 1'b1);
		send(a_cmd, fa, `AMCAC_ERR_FC_FOLLOW, 3'b000);
		host.set_ind(1'b0, 1'b0, 1'b0);
		host.write_reg(a_scale, 32'h00010003);
		host.write_reg(a_vel, 32'hffffff38);
		send(a_cmd, fa, 8'h00, 3'b001);
		check("force_analog", 32'h1, {31'h0, force_analog});
		check("vel_command", 32'hfffffed4, vel_command);
		send(a_ctrl, drv | jrev, `AMCAC_ERR_JG_FORCE, 3'b001);
		host.write_reg(a_ctrl, drv);
		// a servo velocity force replaces the analog one, then a move replaces the force
		send(a_cmd, fs, 8'h00, 3'b001);
		check("force_analog", 32'h0, {31'h0, force_analog});
		send(a_cmd, vm, 8'h00, 3'b100);
		check("vel_command", 32'hfffffed4, vel_command);
		check("force_analog", 32'h0, {31'h0, force_analog});
		// abort ends the move and zeroes the command velocity
		send(a_ctrl, drv | abrt, 8'h00, 3'b000);
		check("vel_command", 32'h0, vel_command);
		send(a_cmd, 32'h0, 8'h00, 3'b000);
		// jog running blocks a force; program needs feedhold for a jog
		send(a_ctrl, drv | jrev, 8'h00, 3'b010);
		send(a_cmd, fs, `AMCAC_ERR_FC_JOG, 3'b010);
		send(a_ctrl, drv, 8'h00, 3'b000);
		host.set_ind(1'b1, 1'b0, 1'b0);
		send(a_ctrl, drv | jfwd, `AMCAC_ERR_JG_PROG, 3'b000);
		host.write_reg(a_ctrl, drv);
		send(a_ctrl, drv | jfwd | fhold, 8'h00, 3'b010);
		expect_reg(a_stat, 32'h00000543, "status");
		// clearing the sticky flag keeps the code and the jog
		host.write_reg(a_stat, 32'h00000100);
		#1;
		check("err_valid", 32'h0, {31'h0, err_valid});
		expect_reg(a_stat, 32'h00000443, "status");
		final_report();
	end

endmodule

`default_nettype wire
